//--- afbh_host.sv
// Host controller that drives the asynchronous flash bus pins
// How it works
// - Reset pin held low at least the minimum, then later recovery awaited.
// - After hardware reset wait for ready_busy_n release before any access.
// - Read: address, chip select and output enable low, write enable high.
// - Output enable kept high for the whole of every write.
`timescale 1ns/1ps
`default_nettype none
module afbh_host
  import afbh_pkg::*;
#(
  parameter int RESET_CYC = RESET_PULSE_CYC,
  parameter int REC_CYC = RECOVERY_CYC
)(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // User request
  input wire logic i_req_valid,
  input wire afbh_req_s i_req,
  input wire logic i_ident,
  input wire logic i_unprotect,
  input wire logic i_hw_reset,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  // Flash pins
  output afbh_pins_s o_pins,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe_n,
  input wire logic i_ready_busy_n
);
  afbh_state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  afbh_pins_s pins_q, pins_d;
  logic [15:0] dq_q, dq_d, oen_q, oen_d, rdat_q, rdat_d;
  logic wr_q, wr_d, byte_q, byte_d, rsp_q, rsp_d;
  logic [1:0] rb_sync_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic rdy;
  logic ready_q;

  // Two flops ahead of any logic on the asynchronous pins
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rb_sync_q <= 2'b00;
      dq_s1_q <= DATA_RST;
      dq_s2_q <= DATA_RST;
    end
    else
    begin
      rb_sync_q <= {rb_sync_q[0], i_ready_busy_n};
      dq_s1_q <= i_dq;
      dq_s2_q <= dq_s1_q;
    end
  end
  assign rdy = rb_sync_q[1];

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    pins_d = pins_q;
    dq_d = dq_q;
    oen_d = oen_q;
    rdat_d = rdat_q;
    wr_d = wr_q;
    byte_d = byte_q;
    rsp_d = 1'b0;
    unique case (st_q)
      ST_IDLE:
      begin
        pins_d.chip_sel_n = 1'b1;
        pins_d.out_en_n = 1'b1;
        pins_d.wr_en_n = 1'b1;
        pins_d.unprotect_hv = i_unprotect;
        oen_d = '1;
        if (i_hw_reset)
        begin
          pins_d.hw_reset_unprotect_n = 1'b0;
          pins_d.unprotect_hv = 1'b0;
          cnt_d = CNT_ZERO;
          st_d = ST_RST_LOW;
        end
        else if (i_req_valid && ready_q)
        begin
          wr_d = i_req.write;
          byte_d = i_req.byte_mode;
          pins_d.byte_word_n = ~i_req.byte_mode;
          pins_d.addr_in = i_req.addr[20:1];
          pins_d.addr9_hv = i_ident && !i_req.write;
          if (i_req.byte_mode)
          begin
            pins_d.addr_in = i_req.addr[20:1];
            dq_d = {i_req.addr[0], 7'h00, i_req.wdata[7:0]};
            oen_d = {1'b0, 7'h7F, {8{~i_req.write}}};
          end
          else
          begin
            pins_d.addr_in = i_req.addr[19:0];
            dq_d = i_req.wdata;
            oen_d = {16{~i_req.write}};
          end
          cnt_d = CNT_ZERO;
          st_d = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        pins_d.chip_sel_n = 1'b0;
        pins_d.out_en_n = wr_q;
        pins_d.wr_en_n = ~wr_q;
        cnt_d = CNT_ZERO;
        st_d = ST_STROBE;
      end
      ST_STROBE:
      begin
        cnt_d = cnt_q + 8'h01;
        if (!wr_q && cnt_q == 8'(ACCESS_CYC + 2))
        begin
          rdat_d = byte_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
          rsp_d = 1'b1;
          cnt_d = CNT_ZERO;
          pins_d.chip_sel_n = 1'b1;
          pins_d.out_en_n = 1'b1;
          st_d = ST_HOLD;
        end
        else if (wr_q && cnt_q == 8'(WRITE_CYC + GLITCH_CYC))
        begin
          pins_d.wr_en_n = 1'b1;
          pins_d.chip_sel_n = 1'b1;
          cnt_d = CNT_ZERO;
          st_d = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        oen_d = '1;
        pins_d.addr9_hv = 1'b0;
        cnt_d = cnt_q + 8'h01;
        // A device turns busy only after the write; wait until that has crossed the sync
        if (cnt_q >= 8'(BUSY_SETTLE_CYC))
          st_d = ST_IDLE;
      end
      ST_RST_LOW:
      begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(RESET_CYC))
        begin
          pins_d.hw_reset_unprotect_n = 1'b1;
          cnt_d = CNT_ZERO;
          st_d = ST_RST_REC;
        end
      end
      ST_RST_REC:
      begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(REC_CYC))
          st_d = ST_WAIT_RDY;
      end
      ST_WAIT_RDY:
      begin
        if (rdy)
          st_d = ST_IDLE;
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      st_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      pins_q <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, byte_word_n: 1'b1,
                  hw_reset_unprotect_n: 1'b1, unprotect_hv: 1'b0, addr9_hv: 1'b0,
                  addr_in: ADDR_RST};
      dq_q <= DATA_RST;
      oen_q <= '1;
      rdat_q <= DATA_RST;
      wr_q <= 1'b0;
      byte_q <= 1'b0;
      rsp_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      dq_q <= dq_d;
      oen_q <= oen_d;
      rdat_q <= rdat_d;
      wr_q <= wr_d;
      byte_q <= byte_d;
      rsp_q <= rsp_d;
    end
  end

  // Ready also gates the take, so a request is taken whenever ready was shown and i_hw_reset is low;
  // the price is one more cycle of lag behind the synchronised busy line.
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      ready_q <= 1'b0;
    else
      ready_q <= (st_d == ST_IDLE) && !i_hw_reset && rdy;
  end

  assign o_req_ready = ready_q;
  assign o_rsp_valid = rsp_q;
  assign o_rsp_data = rdat_q;
  assign o_pins = pins_q;
  assign o_dq = dq_q;
  assign o_dq_oe_n = oen_q;
endmodule : afbh_host
`default_nettype wire

//--- afbh_pkg.sv
// Package for the asynchronous flash bus host controller
package afbh_pkg;
  // Timing, in ns as printed or chosen, and cycles at the 40 MHz clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_RECOVERY_DELAY_NS = 50;
  localparam int READY_RECOVERY_DELAY_NS = 50;
  localparam int ACCESS_TIME_NS = 70;
  localparam int WRITE_PULSE_NS = 45;
  localparam int GLITCH_NS = 5;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_NS = (RESET_RECOVERY_DELAY_NS > READY_RECOVERY_DELAY_NS) ?
                               RESET_RECOVERY_DELAY_NS : READY_RECOVERY_DELAY_NS;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles after the strobes rise before a busy line has crossed the synchroniser
  localparam int BUSY_SETTLE_CYC = 2;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST = 20'h0_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010,
    ST_RST_LOW = 3'b110,
    ST_RST_REC = 3'b111,
    ST_WAIT_RDY = 3'b101
  } afbh_state_e;

  // Request from user logic
  typedef struct packed {
    logic write;
    logic byte_mode;
    logic [20:0] addr;
    logic [15:0] wdata;
  } afbh_req_s;

  // Pins driven toward the flash
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic byte_word_n;
    logic hw_reset_unprotect_n;
    logic unprotect_hv;
    logic addr9_hv;
    logic [19:0] addr_in;
  } afbh_pins_s;
endpackage : afbh_pkg

//--- afbh_host_monitor.sv
// Checker for the flash host pin protocol
`timescale 1ns/1ps
`default_nettype none
module afbh_host_monitor
  import afbh_pkg::*;
(
  // Watched ports
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire afbh_pins_s o_pins,
  input wire logic [15:0] o_dq_oe_n,
  input wire logic o_req_ready,
  input wire logic i_ready_busy_n
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // Two synchroniser flops plus the ready register
  sequence s_busy;
    !i_ready_busy_n [*4];
  endsequence
  a_busy_stall: assert property (s_busy |-> !o_req_ready)
    else $error("ready while busy");
  a_write_oe: assert property (!o_pins.wr_en_n |-> o_pins.out_en_n)
    else $error("output enable low in write");
  a_read_float: assert property (!o_pins.out_en_n |-> &o_dq_oe_n[14:0])
    else $error("host drives data in read");
  a_idle_strobes: assert property (o_pins.chip_sel_n |-> o_pins.out_en_n && o_pins.wr_en_n)
    else $error("strobe low while deselected");
  a_reset_pulse: assert property ($fell(o_pins.hw_reset_unprotect_n) |=>
    !o_pins.hw_reset_unprotect_n)
    else $error("reset pulse too short");
  a_reset_quiet: assert property (!o_pins.hw_reset_unprotect_n |-> o_pins.chip_sel_n)
    else $error("access during reset");
  a_addr_hold: assert property (!o_pins.chip_sel_n && !$past(o_pins.chip_sel_n) |->
    $stable(o_pins.addr_in))
    else $error("address moved in strobe");
  a_hv_reset: assert property (o_pins.unprotect_hv |-> o_pins.hw_reset_unprotect_n)
    else $error("high voltage with reset low");
  a_strobe_width: assert property ($fell(o_pins.wr_en_n) |=> !o_pins.wr_en_n [*2])
    else $error("write strobe too short");
  a_read_hold: assert property ($fell(o_pins.out_en_n) |=> !o_pins.out_en_n [*5])
    else $error("read strobe too short");
endmodule : afbh_host_monitor
bind afbh_host afbh_host_monitor u_mon (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .o_pins(o_pins),
  .o_dq_oe_n(o_dq_oe_n), .o_req_ready(o_req_ready), .i_ready_busy_n(i_ready_busy_n));
`default_nettype wire

//--- afbh_flash_model.sv
// Behavioural flash device on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module afbh_flash_model
  import afbh_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h0A5A, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0C3C // Arbitrary value
)(
  // Pins from the host and resolved data bus
  input wire afbh_pins_s i_pins,
  input wire logic [15:0] i_dq,
  // Device outputs
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_drv,
  output logic o_busy = 1'b0
);
  logic [15:0] mem [16];
  logic [15:0] rd;
  logic [4:0] wa;
  wire st_n = i_pins.chip_sel_n | i_pins.wr_en_n;
  wire rdv = !i_pins.chip_sel_n && !i_pins.out_en_n && i_pins.wr_en_n;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'(i) * 16'h1111;
  // Bits 8 to 15 stay off the bus in byte mode
  assign o_dq_drv = {16{rdv}} & {{8{i_pins.byte_word_n}}, 8'hFF};
  assign rd = i_pins.addr9_hv ? (i_pins.addr_in[0] ? PART_CODE : MAKER_CODE)
    : mem[i_pins.addr_in[3:0]];
  assign o_dq = i_pins.byte_word_n ? rd : {8'h00, i_dq[15] ? rd[15:8] : rd[7:0]};
  always @(negedge st_n) wa = {i_dq[15], i_pins.addr_in[3:0]};
  always @(posedge st_n)
    if (i_pins.byte_word_n)
      mem[wa[3:0]] = i_dq;
    else
      mem[wa[3:0]][{wa[4], 3'b000}+:8] = i_dq[7:0];
  // One busy span at a time; an event inside the span is not seen
  always @(posedge st_n or posedge i_pins.hw_reset_unprotect_n)
  begin
    o_busy = 1'b1;
    // Ends between clock edges so the host never samples it in a race
    #305 o_busy = 1'b0;
  end
endmodule : afbh_flash_model
`default_nettype wire

//--- async_flash_bus_interface_bench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module async_flash_bus_interface_bench import afbh_pkg::*;;
  logic I_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic req_valid = 1'b0;
  logic ident = 1'b0;
  logic unprot = 1'b0;
  logic hw_rst = 1'b0;
  afbh_req_s req = '0;
  afbh_pins_s pins;
  logic ready, rsp_valid, f_busy;
  logic [15:0] rsp_data, dq, h_dq, h_oe_n, f_dq, f_drv;
  logic [15:0] pat = 16'h5A5A;
  int fails = 0;
  int checks_done = 0;
  afbh_req_s rows [6] = '{'{1'b1, 1'b0, 21'h0_0003, 16'hBEEF}, '{1'b0, 1'b0, 21'h0_0003, 16'h0000},
    '{1'b1, 1'b1, 21'h0_0005, 16'h0077}, '{1'b0, 1'b1, 21'h0_0005, 16'h0000},
    '{1'b0, 1'b1, 21'h0_0004, 16'h0000}, '{1'b0, 1'b0, 21'h0_0002, 16'h0000}};
  logic [15:0] exp_d [6] = '{16'h0000, 16'hBEEF, 16'h0000, 16'h0077, 16'h0022, 16'h7722};
  always #12.5 I_CLK = ~I_CLK;
  // Undriven bits toggle so a floating bus never reads as stable data
  always @(posedge I_CLK) pat <= ~pat;
  assign dq = (h_dq & ~h_oe_n) | (f_dq & f_drv) | (pat & h_oe_n & ~f_drv);
  afbh_host #(.RESET_CYC(2)) u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .i_req_valid(req_valid),
    .i_req(req), .i_ident(ident), .i_unprotect(unprot), .i_hw_reset(hw_rst),
    .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_pins(pins),
    .i_dq(dq), .o_dq(h_dq), .o_dq_oe_n(h_oe_n), .i_ready_busy_n(!f_busy));
  afbh_flash_model u_flash (.i_pins(pins), .i_dq(dq), .o_dq(f_dq), .o_dq_drv(f_drv),
    .o_busy(f_busy));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wait_ready;
    for (int n = 0; n < 200 && ready !== 1'b1; n++)
    begin
      @(posedge I_CLK);
      #2;
    end
    chk({15'h0000, ready}, 16'h0001);
  endtask : wait_ready
  task op(input afbh_req_s r, input logic id, input logic [15:0] exp);
    wait_ready;
    req = r;
    ident = id;
    req_valid = 1'b1;
    @(posedge I_CLK);
    #2;
    req_valid = 1'b0;
    for (int n = 0; n < 60 && !r.write && rsp_valid !== 1'b1; n++)
    begin
      @(posedge I_CLK);
      #2;
    end
    if (!r.write)
    begin
      chk({15'h0000, rsp_valid}, 16'h0001);
      chk(rsp_data, exp);
    end
  endtask : op
  task test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (20) @(posedge I_CLK);
    #2;
    chk({13'h0000, pins.chip_sel_n, pins.out_en_n, pins.wr_en_n}, 16'h0007);
    chk(h_oe_n, 16'hFFFF);
    I_RSTN = 1'b1;
    for (int i = 0; i < 6; i++)
      op(rows[i], 1'b0, exp_d[i]);
    $display("table rows done");
    op('{1'b0, 1'b0, 21'h0_0000, 16'h0000}, 1'b1, 16'h0A5A);
    op('{1'b0, 1'b0, 21'h0_0001, 16'h0000}, 1'b1, 16'h0C3C);
    ident = 1'b0;
    $display("identification done");
    wait_ready;
    hw_rst = 1'b1;
    @(posedge I_CLK);
    #2;
    hw_rst = 1'b0;
    @(posedge I_CLK);
    #2;
    chk({15'h0000, pins.hw_reset_unprotect_n}, 16'h0000);
    chk({15'h0000, ready}, 16'h0000);
    op(rows[1], 1'b0, 16'hBEEF);
    $display("hardware reset done");
    unprot = 1'b1;
    wait_ready;
    @(posedge I_CLK);
    #2;
    chk({15'h0000, pins.unprotect_hv}, 16'h0001);
    unprot = 1'b0;
    @(posedge I_CLK);
    #2;
    chk({15'h0000, pins.unprotect_hv}, 16'h0000);
    $display("unprotect done");
    test_done;
  end
  // Nine operations of under 100 cycles each fit well inside this span
  initial
  begin
    #100000;
    fails++;
    test_done;
  end
endmodule : async_flash_bus_interface_bench
`default_nettype wire
